/* logic/ttc_channel.v */
// One timer channel: counter, two match/capture registers and clear logic
`timescale 1ns/1ps
`include "ttc_map.vh"

module ttc_channel #(
   parameter UPDOWN = 0
) (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_standby,
   input wire [6:0] i_ctrl,
   input wire [7:0] i_iosel,
   input wire i_pwm,
   input wire i_phase_on,
   input wire [3:0] i_int_tick,
   input wire [3:0] i_ext,
   input wire i_cap_a,
   input wire i_cap_b,
   input wire i_sync_clr,
   input wire i_wr_cnt,
   input wire i_wr_mca,
   input wire i_wr_mcb,
   input wire [1:0] i_be,
   input wire [15:0] i_wdata,
   output reg [15:0] o_count,
   output reg [15:0] o_mca,
   output reg [15:0] o_mcb,
   output wire o_ev_a,
   output wire o_ev_b,
   output wire o_wrap,
   output wire o_clr_req
);

   reg [3:0] ext_q_r;
   reg cap_a_q_r;
   reg cap_b_q_r;

   // Byte-lane merge for word or byte writes
   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0] be;
      begin
         merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   // Capture edge per field: 00 rising, 01 falling, 1x both
   function cap_edge;
      input [1:0] sel;
      input now;
      input prev;
      begin
         cap_edge = sel[1] ? (now ^ prev) : (sel[0] ? (prev & ~now) : (now & ~prev));
      end
   endfunction

   wire [2:0] src = i_ctrl[`TTC_F_SRC_B2:`TTC_F_SRC_B0];
   wire [1:0] clr_sel = {i_ctrl[`TTC_F_CLR_HI], i_ctrl[`TTC_F_CLR_LO]};
   wire [1:0] edge_sel = {i_ctrl[`TTC_F_EDGE_HI], i_ctrl[`TTC_F_EDGE_LO]};
   wire ext_now = i_ext[src[1:0]];
   wire ext_prev = ext_q_r[src[1:0]];
   wire ext_tick = edge_sel[1] ? (ext_now ^ ext_prev) : cap_edge(2'h1 & edge_sel, ext_now, ext_prev);
   wire tick = src[2] ? ext_tick : i_int_tick[src[1:0]];
   // Phase decode on clock pins A and B, every transition counts
   wire phase = (UPDOWN != 0) & i_phase_on;
   wire step = (i_ext[0] ^ ext_q_r[0]) | (i_ext[1] ^ ext_q_r[1]);
   wire up = i_ext[0] ^ ext_q_r[1];
   wire count_en = phase ? step : tick;
   wire down = phase & ~up;
   // PWM mode treats both registers as plain compare registers
   wire [2:0] io_a = i_pwm ? 3'h0 : i_iosel[`TTC_F_IO_A+2:`TTC_F_IO_A];
   wire [2:0] io_b = i_pwm ? 3'h0 : i_iosel[`TTC_F_IO_B+2:`TTC_F_IO_B];
   wire cap_a = io_a[`TTC_F_IO_CAP] & cap_edge(io_a[1:0], i_cap_a, cap_a_q_r);
   wire cap_b = io_b[`TTC_F_IO_CAP] & cap_edge(io_b[1:0], i_cap_b, cap_b_q_r);
   wire cmp_a = ~io_a[`TTC_F_IO_CAP] & (o_count == o_mca);
   wire cmp_b = ~io_b[`TTC_F_IO_CAP] & (o_count == o_mcb);
   wire clr;
   wire wrap_val = down ? (o_count == 16'h0000) : (o_count == 16'hFFFF);

   assign o_ev_a = cap_a | cmp_a;
   assign o_ev_b = cap_b | cmp_b;
   // Clear follows whichever event the register produces, compare or capture
   assign o_clr_req = ((clr_sel == `TTC_CLR_A) & o_ev_a) | ((clr_sel == `TTC_CLR_B) & o_ev_b);
   assign clr = o_clr_req | ((clr_sel == `TTC_CLR_SYNC) & i_sync_clr);
   // A write or clear in the same cycle pre-empts the wrap
   assign o_wrap = count_en & wrap_val & ~clr & ~i_wr_cnt;

   // Previous pin levels for edge detection, inputs arrive synchronised
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_q_r <= 4'h0;
         cap_a_q_r <= 1'b0;
         cap_b_q_r <= 1'b0;
      end else begin
         ext_q_r <= i_ext;
         cap_a_q_r <= i_cap_a;
         cap_b_q_r <= i_cap_b;
      end
   end

   // Counter and registers, processor write wins over hardware updates
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count <= `TTC_RST_COUNT;
         o_mca <= `TTC_RST_MC;
         o_mcb <= `TTC_RST_MC;
      end else if (i_standby) begin
         o_count <= `TTC_RST_COUNT;
         o_mca <= `TTC_RST_MC;
         o_mcb <= `TTC_RST_MC;
      end else begin
         if (i_wr_cnt) begin
            o_count <= merge(o_count, i_wdata, i_be);
         end else if (clr) begin
            o_count <= 16'h0000;
         end else if (count_en) begin
            o_count <= down ? o_count - 16'h0001 : o_count + 16'h0001;
         end
         if (i_wr_mca) begin
            o_mca <= merge(o_mca, i_wdata, i_be);
         end else if (cap_a) begin
            o_mca <= o_count;
         end
         if (i_wr_mcb) begin
            o_mcb <= merge(o_mcb, i_wdata, i_be);
         end else if (cap_b) begin
            o_mcb <= o_count;
         end
      end
   end

endmodule // ttc_channel

/* logic/ttc_map.vh */
// Register indices, field positions and reset values of the three-channel timer
`ifndef TTC_MAP_VH
`define TTC_MAP_VH

// Word indices on the internal 16-bit bus, channel n at base + n
`define TTC_A_COUNT 5'h00
`define TTC_A_MCA 5'h03
`define TTC_A_MCB 5'h06
`define TTC_A_CTRL 5'h09
`define TTC_A_IOSEL 5'h0C
`define TTC_A_STAT_A 5'h0F
`define TTC_A_STAT_B 5'h10
`define TTC_A_WRAP 5'h11
`define TTC_A_MODE 5'h12
`define TTC_A_SYNC 5'h13

// Reset values
`define TTC_RST_COUNT 16'h0000
`define TTC_RST_MC 16'hFFFF
`define TTC_RST_CTRL 8'h80
`define TTC_RST_IOSEL 8'h88
`define TTC_RST_STAT 8'h88
`define TTC_RST_MODE 8'h00
`define TTC_RST_SYNC 8'h00

// count_control fields
`define TTC_F_CLR_HI 6
`define TTC_F_CLR_LO 5
`define TTC_F_EDGE_HI 4
`define TTC_F_EDGE_LO 3
`define TTC_F_SRC_B2 2
`define TTC_F_SRC_B0 0

// Clear-source encodings
`define TTC_CLR_NONE 2'h0
`define TTC_CLR_A 2'h1
`define TTC_CLR_B 2'h2
`define TTC_CLR_SYNC 2'h3

// io_function_select: function A in 2:0, B in 6:4; bit 2 of a field picks capture
`define TTC_F_IO_A 0
`define TTC_F_IO_B 4
`define TTC_F_IO_CAP 2

// Status registers: enables at 6:4, flags at 2:0, bits 7 and 3 read as one
`define TTC_F_EN 4
`define TTC_F_FLAG 0

// timer_mode_control: PWM per channel at 2:0, phase_count_on at 6
`define TTC_F_PWM 0
`define TTC_F_PHASE 6

// Prescaler width, phi/8 is the slowest internal source
`define TTC_PRE_W 3

`endif

/* logic/ttc_top.v */
// Three-channel 16-bit timer with its register file on the internal CPU bus
`timescale 1ns/1ps
`include "ttc_map.vh"

// Operation
// - Three 16-bit counters; channel 2 counts down too, only in phase counting
// - Reset or standby forces every counter to zero
// - Counter wrapping all ones to zero sets its wrap flag
// - Counter stepping zero down to all ones sets its wrap flag
// - Clear-source field: none, register A event, register B event, synchronous group
// - Register clear follows compare match or capture, whichever function is chosen
// - Six match/capture registers reset to all ones in compare function
// - Compare register equal to counter sets its event flag
// - Capture edge copies counter into register and sets event flag together
// - Function select picks compare or capture; ignored in PWM mode
// - Control register resets to 0x80; bit 7 fixed at one
// - Edge-select field picks rising, falling or both external clock edges
// - Clock-source field picks phi divided by 1,2,4,8 or external A-D
// - Internal sources count on falling edges; external use the edge select
// - Phase counting on channel 2 overrides source and edge fields
// - Counters and registers take word and byte reads and writes
// - A flag clears only after a read as one then a zero write
// - Down-count wrap happens only on channel 2 in phase counting
// - Interrupt request follows a flag only while its enable is set
module ttc_top (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_standby,
   input wire [4:0] i_addr,
   input wire i_rd,
   input wire i_wr,
   input wire [1:0] i_be,
   input wire [15:0] i_wdata,
   output reg [15:0] o_rdata,
   input wire i_ext_clock_a,
   input wire i_ext_clock_b,
   input wire i_ext_clock_c,
   input wire i_ext_clock_d,
   input wire [2:0] i_capture_a,
   input wire [2:0] i_capture_b,
   output wire [2:0] o_irq_match_a,
   output wire [2:0] o_irq_match_b,
   output wire [2:0] o_irq_wrap
);

   // Reset release synchroniser
   reg [1:0] rst_q_r;
   wire rst_n = rst_q_r[1];

   // Pin synchronisers: four clock pins then six capture pins
   reg [9:0] pin_s1_r;
   reg [9:0] pin_s2_r;
   wire [3:0] ext_s = pin_s2_r[3:0];
   wire [2:0] cap_a_s = pin_s2_r[6:4];
   wire [2:0] cap_b_s = pin_s2_r[9:7];

   // Prescaler and internal count ticks
   reg [`TTC_PRE_W-1:0] pre_r;
   wire [3:0] int_tick;

   // Software-visible state
   reg [20:0] ctrl_r;
   reg [17:0] iosel_r;
   reg [2:0] flag_a_r;
   reg [2:0] flag_b_r;
   reg [2:0] flag_w_r;
   reg [2:0] en_a_r;
   reg [2:0] en_b_r;
   reg [2:0] en_w_r;
   reg [2:0] arm_a_r;
   reg [2:0] arm_b_r;
   reg [2:0] arm_w_r;
   reg [2:0] pwm_r;
   reg phase_r;
   reg [2:0] sync_r;

   // Channel outputs gathered flat
   wire [47:0] count_w;
   wire [47:0] mca_w;
   wire [47:0] mcb_w;
   wire [2:0] ev_a;
   wire [2:0] ev_b;
   wire [2:0] wrap;
   wire [2:0] clr_req;
   wire group_clr = |(clr_req & sync_r);

   // Status, mode and sync register selects
   wire sel_sa = (i_addr == `TTC_A_STAT_A);
   wire sel_sb = (i_addr == `TTC_A_STAT_B);
   wire sel_sw = (i_addr == `TTC_A_WRAP);
   wire sel_mode = (i_addr == `TTC_A_MODE);
   wire sel_sync = (i_addr == `TTC_A_SYNC);
   reg [15:0] rd_nxt;

   // Two flip-flops on reset release, the assertion side stays asynchronous
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_q_r <= 2'h0;
      end else begin
         rst_q_r <= {rst_q_r[0], 1'b1};
      end
   end

   // Two-stage pin synchroniser; only stage two feeds the edge detectors
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 10'h000;
         pin_s2_r <= 10'h000;
      end else begin
         pin_s1_r <= {i_capture_b, i_capture_a, i_ext_clock_d, i_ext_clock_c,
                      i_ext_clock_b, i_ext_clock_a};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Free-running prescaler shared by all channels
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= {`TTC_PRE_W{1'b0}};
      end else if (i_standby) begin
         pre_r <= {`TTC_PRE_W{1'b0}};
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end

   // A tick marks the cycle in which the divided clock falls
   assign int_tick = {pre_r == 3'h7, pre_r[1:0] == 2'h3, pre_r[0], 1'b1};

   // Per-channel datapath
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ch
         wire hit_cnt = (i_addr == `TTC_A_COUNT + g);
         wire hit_mca = (i_addr == `TTC_A_MCA + g);
         wire hit_mcb = (i_addr == `TTC_A_MCB + g);

         ttc_channel #(
            .UPDOWN(g == 2)
         ) u_ch (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(rst_n),
            .i_standby(i_standby),
            .i_ctrl(ctrl_r[7*g+6:7*g]),
            .i_iosel({1'b1, iosel_r[6*g+5:6*g+3], 1'b1, iosel_r[6*g+2:6*g]}),
            .i_pwm(pwm_r[g]),
            .i_phase_on(phase_r),
            .i_int_tick(int_tick),
            .i_ext(ext_s),
            .i_cap_a(cap_a_s[g]),
            .i_cap_b(cap_b_s[g]),
            .i_sync_clr(sync_r[g] & group_clr),
            .i_wr_cnt(i_wr & hit_cnt),
            .i_wr_mca(i_wr & hit_mca),
            .i_wr_mcb(i_wr & hit_mcb),
            .i_be(i_be),
            .i_wdata(i_wdata),
            .o_count(count_w[16*g+15:16*g]),
            .o_mca(mca_w[16*g+15:16*g]),
            .o_mcb(mcb_w[16*g+15:16*g]),
            .o_ev_a(ev_a[g]),
            .o_ev_b(ev_b[g]),
            .o_wrap(wrap[g]),
            .o_clr_req(clr_req[g])
         );
      end
   endgenerate

   // Control and function-select registers; 8-bit, written on the low lane
   integer i;
   integer j;
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= 21'h000000;
         iosel_r <= 18'h00000;
         pwm_r <= 3'h0;
         phase_r <= 1'b0;
         sync_r <= 3'h0;
      end else if (i_standby) begin
         ctrl_r <= 21'h000000;
         iosel_r <= 18'h00000;
         pwm_r <= 3'h0;
         phase_r <= 1'b0;
         sync_r <= 3'h0;
      end else if (i_wr && i_be[0]) begin
         for (j = 0; j < 3; j = j + 1) begin
            // Bit 7 is not stored, so writes to it vanish
            if (i_addr == `TTC_A_CTRL + j) begin
               ctrl_r[7*j +: 7] <= i_wdata[6:0];
            end
            if (i_addr == `TTC_A_IOSEL + j) begin
               iosel_r[6*j +: 6] <= {i_wdata[6:4], i_wdata[2:0]};
            end
         end
         if (sel_mode) begin
            pwm_r <= i_wdata[`TTC_F_PWM+2:`TTC_F_PWM];
            phase_r <= i_wdata[`TTC_F_PHASE];
         end
         if (sel_sync) begin
            sync_r <= i_wdata[2:0];
         end
      end
   end

   // Flags: a new event always beats the software clear in the same cycle
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_a_r <= 3'h0;
         flag_b_r <= 3'h0;
         flag_w_r <= 3'h0;
      end else if (i_standby) begin
         flag_a_r <= 3'h0;
         flag_b_r <= 3'h0;
         flag_w_r <= 3'h0;
      end else begin
         flag_a_r <= ev_a | (flag_a_r & ~({3{i_wr & i_be[0] & sel_sa}} & ~i_wdata[2:0] & arm_a_r));
         flag_b_r <= ev_b | (flag_b_r & ~({3{i_wr & i_be[0] & sel_sb}} & ~i_wdata[2:0] & arm_b_r));
         flag_w_r <= wrap | (flag_w_r & ~({3{i_wr & i_be[0] & sel_sw}} & ~i_wdata[2:0] & arm_w_r));
      end
   end

   // Read of a one arms the clear; any write to the register disarms it
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         arm_a_r <= 3'h0;
         arm_b_r <= 3'h0;
         arm_w_r <= 3'h0;
      end else if (i_standby) begin
         arm_a_r <= 3'h0;
         arm_b_r <= 3'h0;
         arm_w_r <= 3'h0;
      end else begin
         if (i_wr && sel_sa) begin
            arm_a_r <= 3'h0;
         end else if (i_rd && sel_sa) begin
            arm_a_r <= arm_a_r | flag_a_r;
         end
         if (i_wr && sel_sb) begin
            arm_b_r <= 3'h0;
         end else if (i_rd && sel_sb) begin
            arm_b_r <= arm_b_r | flag_b_r;
         end
         if (i_wr && sel_sw) begin
            arm_w_r <= 3'h0;
         end else if (i_rd && sel_sw) begin
            arm_w_r <= arm_w_r | flag_w_r;
         end
      end
   end

   // Interrupt enables live in bits 6:4 of each status register
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         en_a_r <= 3'h0;
         en_b_r <= 3'h0;
         en_w_r <= 3'h0;
      end else if (i_standby) begin
         en_a_r <= 3'h0;
         en_b_r <= 3'h0;
         en_w_r <= 3'h0;
      end else if (i_wr && i_be[0]) begin
         if (sel_sa) begin
            en_a_r <= i_wdata[`TTC_F_EN+2:`TTC_F_EN];
         end
         if (sel_sb) begin
            en_b_r <= i_wdata[`TTC_F_EN+2:`TTC_F_EN];
         end
         if (sel_sw) begin
            en_w_r <= i_wdata[`TTC_F_EN+2:`TTC_F_EN];
         end
      end
   end

   // Requests are levels; they drop when the flag or the enable drops
   assign o_irq_match_a = flag_a_r & en_a_r;
   assign o_irq_match_b = flag_b_r & en_b_r;
   assign o_irq_wrap = flag_w_r & en_w_r;

   // Read mux; 8-bit registers sit in the low byte, unmapped reads as zero
   always @* begin
      rd_nxt = 16'h0000;
      for (i = 0; i < 3; i = i + 1) begin
         if (i_addr == `TTC_A_COUNT + i) begin
            rd_nxt = count_w[16*i +: 16];
         end
         if (i_addr == `TTC_A_MCA + i) begin
            rd_nxt = mca_w[16*i +: 16];
         end
         if (i_addr == `TTC_A_MCB + i) begin
            rd_nxt = mcb_w[16*i +: 16];
         end
         if (i_addr == `TTC_A_CTRL + i) begin
            rd_nxt = {8'h00, 1'b1, ctrl_r[7*i +: 7]};
         end
         if (i_addr == `TTC_A_IOSEL + i) begin
            rd_nxt = {8'h00, 1'b1, iosel_r[6*i+3 +: 3], 1'b1, iosel_r[6*i +: 3]};
         end
      end
      if (sel_sa) begin
         rd_nxt = {8'h00, 1'b1, en_a_r, 1'b1, flag_a_r};
      end
      if (sel_sb) begin
         rd_nxt = {8'h00, 1'b1, en_b_r, 1'b1, flag_b_r};
      end
      if (sel_sw) begin
         rd_nxt = {8'h00, 1'b1, en_w_r, 1'b1, flag_w_r};
      end
      if (sel_mode) begin
         rd_nxt = {9'h000, phase_r, 3'h0, pwm_r};
      end
      if (sel_sync) begin
         rd_nxt = {13'h0000, sync_r};
      end
   end

   // Read data is registered and holds until the next read
   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= rd_nxt;
      end
   end

endmodule // ttc_top

/* verification/tb.sv */
// Self-checking testbench for the three-channel timer
`timescale 1ns/1ps
module tb;
   reg i_clk_sys = 1'b0;
   reg i_reset_n = 1'b0;
   reg i_standby = 1'b0;
   reg i_rd = 1'b0;
   reg i_wr = 1'b0;
   reg [4:0] i_addr = 5'h00;
   reg [1:0] i_be = 2'h0;
   reg [15:0] i_wdata = 16'h0000;
   wire [15:0] o_rdata;
   wire [3:0] ext_w;
   wire [2:0] cap_a_w, cap_b_w, irq_a_w, irq_b_w, irq_w_w;
   integer failures = 0;
   integer cmp_count = 0;
   integer k;
   reg [15:0] v, v2;

   always #5 i_clk_sys = ~i_clk_sys;

   ttc_top dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_standby(i_standby), .i_addr(i_addr),
      .i_rd(i_rd), .i_wr(i_wr), .i_be(i_be), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .i_ext_clock_a(ext_w[0]), .i_ext_clock_b(ext_w[1]), .i_ext_clock_c(ext_w[2]), .i_ext_clock_d(ext_w[3]),
      .i_capture_a(cap_a_w), .i_capture_b(cap_b_w), .o_irq_match_a(irq_a_w), .o_irq_match_b(irq_b_w),
      .o_irq_wrap(irq_w_w));
   ttc_pins pins_u (.i_clk_sys(i_clk_sys), .o_ext_clock(ext_w), .o_capture_a(cap_a_w), .o_capture_b(cap_b_w));

   task bus_wr(input [4:0] a, input [1:0] b, input [15:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_be <= b;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // Read data is registered, so it is taken two edges after the request
   task bus_rd(input [4:0] a, output [15:0] d);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
      #1 d = o_rdata;
   endtask

   task check(input [15:0] got, input [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Free-running counts are only bounded, their phase is not fixed
   task chk_max(input [15:0] got, input [15:0] lim);
      cmp_count = cmp_count + 1;
      if ((got <= lim) !== 1'b1) begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h expected at most %h", $time, got, lim);
      end
   endtask

   task rd_chk(input [4:0] a, input [15:0] m, input [15:0] e);
      bus_rd(a, v);
      check(v & m, e);
   endtask

   task end_of_test;
      $display("compares %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      failures = failures + 1;
      $display("timeout at %0t", $time);
      end_of_test;
   end

   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      for (k = 3; k < 21; k = k + 1) begin
         rd_chk(k[4:0], (k < 9 || k > 19) ? 16'hFFFF : 16'h00FF, (k < 9) ? 16'hFFFF : (k < 12) ? 16'h0080 :
            (k < 18) ? 16'h0088 : 16'h0000);
      end
      $display("done: reset values");
      bus_wr(5'h09, 2'h1, 16'h0004);
      bus_wr(5'h00, 2'h3, 16'h1234);
      rd_chk(5'h00, 16'hFFFF, 16'h1234);
      bus_wr(5'h00, 2'h1, 16'h00AB);
      rd_chk(5'h00, 16'hFFFF, 16'h12AB);
      bus_wr(5'h00, 2'h2, 16'hCD00);
      rd_chk(5'h00, 16'hFFFF, 16'hCDAB);
      bus_wr(5'h03, 2'h2, 16'h5600);
      rd_chk(5'h03, 16'hFFFF, 16'h56FF);
      bus_wr(5'h0B, 2'h1, 16'h007F);
      rd_chk(5'h0B, 16'h00FF, 16'h00FF);
      $display("done: byte access");
      for (k = 0; k < 4; k = k + 1) begin
         bus_wr(5'h09, 2'h1, {11'h000, k[1:0], 3'h4});
         bus_wr(5'h00, 2'h3, 16'h0000);
         pins_u.set_pin(0, 1'b1, 6);
         rd_chk(5'h00, 16'hFFFF, (k == 1) ? 16'h0000 : 16'h0001);
         pins_u.set_pin(0, 1'b0, 6);
         rd_chk(5'h00, 16'hFFFF, (k > 1) ? 16'h0002 : 16'h0001);
      end
      for (k = 0; k < 4; k = k + 1) begin
         bus_wr(5'h09, 2'h1, {13'h0000, 1'b1, k[1:0]});
         bus_wr(5'h00, 2'h3, 16'h0000);
         repeat (3) begin
            pins_u.set_pin(k, 1'b1, 2);
            pins_u.set_pin(k, 1'b0, 2);
         end
         pins_u.set_pin((k + 1) % 4, 1'b1, 4);
         pins_u.set_pin((k + 1) % 4, 1'b0, 4);
         rd_chk(5'h00, 16'hFFFF, 16'h0003);
      end
      $display("done: external clocks");
      bus_wr(5'h09, 2'h1, 16'h0004);
      bus_wr(5'h00, 2'h3, 16'hFFFF);
      bus_wr(5'h0B, 2'h1, 16'h0004);
      bus_wr(5'h02, 2'h3, 16'h0002);
      bus_wr(5'h12, 2'h1, 16'h0040);
      pins_u.set_pin(1, 1'b1, 4);
      pins_u.set_pin(0, 1'b1, 4);
      pins_u.set_pin(1, 1'b0, 4);
      pins_u.set_pin(0, 1'b0, 4);
      rd_chk(5'h02, 16'hFFFF, 16'hFFFE);
      rd_chk(5'h00, 16'hFFFF, 16'h0000);
      rd_chk(5'h11, 16'h0005, 16'h0005);
      bus_wr(5'h11, 2'h1, 16'h0077);
      #1 check({13'h0000, irq_w_w}, 16'h0005);
      pins_u.set_pin(0, 1'b1, 4);
      pins_u.set_pin(1, 1'b1, 4);
      pins_u.set_pin(0, 1'b0, 4);
      pins_u.set_pin(1, 1'b0, 4);
      rd_chk(5'h02, 16'hFFFF, 16'h0002);
      rd_chk(5'h00, 16'hFFFF, 16'h0001);
      bus_wr(5'h11, 2'h1, 16'h0070);
      rd_chk(5'h11, 16'h0005, 16'h0005);
      bus_wr(5'h11, 2'h1, 16'h0070);
      rd_chk(5'h11, 16'h0077, 16'h0070);
      check({13'h0000, irq_w_w}, 16'h0000);
      $display("done: phase counting and wrap flags");
      bus_wr(5'h12, 2'h1, 16'h0000);
      for (k = 1; k < 3; k = k + 1) begin
         if (k == 1) begin
            bus_wr(5'h04, 2'h3, 16'h0008);
         end else begin
            bus_wr(5'h04, 2'h3, 16'h0030);
            bus_wr(5'h07, 2'h3, 16'h0008);
         end
         bus_wr(5'h0A, 2'h1, {9'h000, k[1:0], 5'h00});
         // Restart below the new limit, or the counter runs past it to the wrap
         bus_wr(5'h01, 2'h3, 16'h0000);
         repeat (40) @(posedge i_clk_sys);
         bus_rd(5'h01, v);
         chk_max(v, 16'h0008);
         repeat (37) @(posedge i_clk_sys);
         bus_rd(5'h01, v);
         chk_max(v, 16'h0008);
         rd_chk(5'h0E + k[4:0], 16'h0002, 16'h0002);
      end
      bus_wr(5'h0F, 2'h1, 16'h0027);
      #1 check({13'h0000, irq_a_w}, 16'h0002);
      bus_wr(5'h10, 2'h1, 16'h0027);
      #1 check({13'h0000, irq_b_w}, 16'h0002);
      $display("done: compare clear");
      bus_wr(5'h0A, 2'h1, 16'h0025);
      bus_rd(5'h0F, v);
      bus_wr(5'h0F, 2'h1, 16'h0000);
      for (k = 0; k < 3; k = k + 1) begin
         bus_wr(5'h0D, 2'h1, {13'h0000, 1'b1, k[1:0]});
         bus_wr(5'h01, 2'h3, 16'h0100 + k[15:0]);
         pins_u.set_pin(5, 1'b1, 6);
         bus_wr(5'h01, 2'h3, 16'h0200 + k[15:0]);
         pins_u.set_pin(5, 1'b0, 6);
         rd_chk(5'h04, 16'hFFFF, (k == 0) ? 16'h0100 : 16'h0200 + k[15:0]);
         rd_chk(5'h01, 16'hFFFF, (k == 0) ? 16'h0200 : 16'h0000);
      end
      // PWM on channel 1 turns the capture setting into plain compare
      bus_wr(5'h12, 2'h1, 16'h0002);
      bus_wr(5'h01, 2'h3, 16'h0300);
      pins_u.set_pin(5, 1'b1, 6);
      rd_chk(5'h04, 16'hFFFF, 16'h0202);
      bus_wr(5'h12, 2'h1, 16'h0000);
      rd_chk(5'h0F, 16'h0002, 16'h0002);
      $display("done: capture");
      for (k = 0; k < 4; k = k + 1) begin
         bus_wr(5'h0B, 2'h1, {14'h0000, k[1:0]});
         bus_rd(5'h02, v);
         repeat (61) @(posedge i_clk_sys);
         bus_rd(5'h02, v2);
         check(v2 - v, 16'h0040 >> k);
      end
      $display("done: prescaler");
      @(posedge i_clk_sys);
      i_standby <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_standby <= 1'b0;
      bus_rd(5'h00, v);
      chk_max(v, 16'h0008);
      rd_chk(5'h03, 16'hFFFF, 16'hFFFF);
      rd_chk(5'h09, 16'h00FF, 16'h0080);
      $display("done: standby");
      end_of_test;
   end
endmodule // tb

/* verification/ttc_chk.sv */
// Port-level checker for the three-channel timer
`timescale 1ns/1ps
module ttc_chk (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_standby,
   input wire [4:0] i_addr,
   input wire i_rd,
   input wire i_wr,
   input wire [1:0] i_be,
   input wire [15:0] i_wdata,
   input wire [15:0] o_rdata,
   input wire [2:0] o_irq_match_a,
   input wire [2:0] o_irq_match_b,
   input wire [2:0] o_irq_wrap
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   // The reset synchroniser keeps read data and wrap requests quiet on the release edge
   rst_quiet_a: assert property ($rose(i_reset_n) |-> o_rdata == 16'h0000 && o_irq_wrap == 3'h0)
      else $error("output active at reset release");
   // Standby drops every enable, so no request may follow
   standby_quiet_a: assert property (i_standby |=> (o_irq_match_a | o_irq_match_b | o_irq_wrap) == 3'h0)
      else $error("interrupt request after standby");
   ctrl_bit7_a: assert property (i_rd && !i_standby && i_addr >= 5'h09 && i_addr <= 5'h0B |=> o_rdata[7])
      else $error("control bit 7 read as zero");
   io_reserved_a: assert property (i_rd && !i_standby && i_addr >= 5'h0C && i_addr <= 5'h0E
      |=> o_rdata[7] && o_rdata[3])
      else $error("function select reserved bits read as zero");
   unmapped_zero_a: assert property (i_rd && !i_standby && i_addr > 5'h13 |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // Read data must stand until the next read
   rdata_hold_a: assert property ((!i_rd && !i_standby) ##1 !i_standby |-> $stable(o_rdata))
      else $error("read data changed without a read");
   mask_match_a_a: assert property (i_wr && !i_standby && i_addr == 5'h0F && i_be[0]
      |=> (o_irq_match_a & ~$past(i_wdata[6:4])) == 3'h0)
      else $error("match A request while disabled");
   mask_match_b_a: assert property (i_wr && !i_standby && i_addr == 5'h10 && i_be[0]
      |=> (o_irq_match_b & ~$past(i_wdata[6:4])) == 3'h0)
      else $error("match B request while disabled");
   mask_wrap_a: assert property (i_wr && !i_standby && i_addr == 5'h11 && i_be[0]
      |=> (o_irq_wrap & ~$past(i_wdata[6:4])) == 3'h0)
      else $error("wrap request while disabled");

   wrap_read_c: cover property (i_rd && i_addr == 5'h11);
   standby_c: cover property (i_standby);
   wrap_irq_c: cover property (o_irq_wrap != 3'h0);
endmodule // ttc_chk

bind ttc_top ttc_chk chk_u (
   .i_clk_sys(i_clk_sys),
   .i_reset_n(i_reset_n),
   .i_standby(i_standby),
   .i_addr(i_addr),
   .i_rd(i_rd),
   .i_wr(i_wr),
   .i_be(i_be),
   .i_wdata(i_wdata),
   .o_rdata(o_rdata),
   .o_irq_match_a(o_irq_match_a),
   .o_irq_match_b(o_irq_match_b),
   .o_irq_wrap(o_irq_wrap)
);

/* verification/ttc_pins.sv */
// Far-side model: external clock and capture pins of the timer
`timescale 1ns/1ps
module ttc_pins (
   input wire i_clk_sys,
   output wire [3:0] o_ext_clock,
   output wire [2:0] o_capture_a,
   output wire [2:0] o_capture_b
);
   reg [9:0] pin_r = 10'h000;

   // Pins 0-3 are clocks A-D, 4-6 capture A, 7-9 capture B
   assign o_ext_clock = pin_r[3:0];
   assign o_capture_a = pin_r[6:4];
   assign o_capture_b = pin_r[9:7];

   // A level is held w cycles; short holds model a prompt pin, long ones a slow pin
   task automatic set_pin(input integer idx, input lvl, input integer w);
      @(posedge i_clk_sys);
      pin_r[idx] <= lvl;
      repeat (w) @(posedge i_clk_sys);
   endtask
endmodule // ttc_pins
